// ==== hw/hbpa_dev.sv ====
// Device end: bus arbiter and slave register port
`timescale 1ns/1ps
`include "hbpa_map.svh"
module hbpa_dev import hbpa_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cpu_mode_i,
  input wire logic dma_req_i,
  input wire logic dma_done_i,
  output logic dma_go_o,
  hbpa_if.dev bus
);
  typedef struct packed {
    hbpa_arb_t arb;
    logic pre_granted;
    logic [1:0] dcnt;
    logic req_n;
    logic busy_oe;
    logic chain_n;
    logic go;
    hbpa_slv_t slv;
    logic [2:0] t;
    logic is_rd;
    logic hbe_n;
    logic [7:0] addr;
    logic [15:0] dout;
    logic doe;
    logic wait_lvl;
  } hbpa_dev_st_t;
  hbpa_dev_st_t st_reg, st_next;
  logic [7:0] regs_reg [`HBPA_REGS];
  logic grant, want, wr_lo, wr_hi;
  logic [15:0] rdata;
  logic [7:0] ev_a, od_a;

  // Mode 0 hold pair is active high
  assign grant = (cpu_mode_i == `HBPA_MODE0) ? bus.hold_grant : !bus.bus_grant_n;
  assign want = dma_req_i && !dma_done_i;
  assign ev_a = {st_reg.addr[7:1], 1'b0};
  assign od_a = {st_reg.addr[7:1], 1'b1};

  always_comb begin
    if (cpu_mode_i == `HBPA_MODE1) begin
      rdata = {8'h00, regs_reg[st_reg.addr[6:0]]};
    end else if (cpu_mode_i == `HBPA_MODE0) begin
      rdata = {regs_reg[od_a[6:0]], regs_reg[ev_a[6:0]]};
    end else begin
      rdata = {regs_reg[ev_a[6:0]], regs_reg[od_a[6:0]]};
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.go = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    case (st_reg.arb)
      HBPA_IDLE: begin
        st_next.dcnt = 2'h0;
        st_next.chain_n = !(grant && !want);
        if (want) begin
          st_next.pre_granted = grant;
          if (grant) begin
            if (bus.busy) begin
              st_next.busy_oe = 1'b1;
              st_next.arb = HBPA_CLAIM;
            end else begin
              st_next.arb = HBPA_REQ;
            end
          end else begin
            st_next.req_n = 1'b0;
            st_next.arb = HBPA_REQ;
          end
        end
      end
      HBPA_REQ: begin
        st_next.chain_n = 1'b1;
        st_next.req_n = 1'b0;
        if (!want) begin
          st_next.req_n = 1'b1;
          st_next.arb = HBPA_IDLE;
        end else if (grant && bus.busy) begin
          st_next.busy_oe = 1'b1;
          st_next.arb = HBPA_CLAIM;
        end
      end
      HBPA_CLAIM: begin
        st_next.req_n = 1'b0;
        st_next.chain_n = 1'b1;
        st_next.go = 1'b1;
        st_next.arb = HBPA_DMA;
      end
      HBPA_DMA: begin
        st_next.chain_n = 1'b1;
        st_next.dcnt = st_reg.dcnt + 2'h1;
        if (st_reg.dcnt == `HBPA_DMA_STATES - 2'h1) begin
          st_next.dcnt = 2'h0;
          if (!want) begin
            st_next.req_n = 1'b1;
            st_next.busy_oe = 1'b0;
            st_next.arb = HBPA_IDLE;
          end else if (!grant) begin
            st_next.busy_oe = 1'b0;
            st_next.arb = HBPA_REL;
          end else begin
            st_next.go = 1'b1;
          end
        end
      end
      HBPA_REL: begin
        st_next.arb = HBPA_REQ;
      end
      default: st_next.arb = HBPA_IDLE;
    endcase
    if (!grant) begin
      st_next.chain_n = 1'b1;
    end

    // slave only drives wait and data
    case (st_reg.slv)
      HBPA_S_IDLE: begin
        st_next.wait_lvl = 1'b1;
        st_next.doe = 1'b0;
        if (!bus.cs_n) begin
          st_next.addr = bus.addr;
          st_next.hbe_n = bus.high_byte_enable_n;
          st_next.slv = HBPA_S_WAIT;
        end
      end
      HBPA_S_WAIT: begin
        st_next.t = 3'h0;
        if (bus.cs_n) begin
          st_next.slv = HBPA_S_IDLE;
        end else if (!bus.rd_n || !bus.wr_n) begin
          st_next.is_rd = !bus.rd_n;
          st_next.wait_lvl = 1'b0;
          st_next.slv = HBPA_S_ACT;
        end
      end
      HBPA_S_ACT: begin
        st_next.t = st_reg.t + 3'h1;
        if (st_reg.is_rd && st_reg.t == ((cpu_mode_i == `HBPA_MODE1) ?
            `HBPA_M1_DRIVE_T : `HBPA_DRIVE_T)) begin
          st_next.dout = rdata;
          st_next.doe = 1'b1;
        end
        if (!st_reg.is_rd && st_reg.t == ((cpu_mode_i == `HBPA_MODE1) ?
            `HBPA_M1_STORE_T : `HBPA_M0_STORE_T)) begin
          wr_lo = 1'b1;
          // mode 0 high lane needs byte enable
          wr_hi = (cpu_mode_i != `HBPA_MODE1) && !(cpu_mode_i == `HBPA_MODE0 && st_reg.hbe_n);
          st_next.slv = HBPA_S_END;
        end
        if (st_reg.is_rd && bus.rd_n) begin
          st_next.doe = 1'b0;
          st_next.wait_lvl = 1'b1;
          st_next.slv = HBPA_S_END;
        end
      end
      HBPA_S_END: begin
        if (bus.rd_n && bus.wr_n) begin
          st_next.wait_lvl = 1'b1;
          st_next.doe = 1'b0;
          st_next.slv = bus.cs_n ? HBPA_S_IDLE : HBPA_S_WAIT;
        end
      end
      default: st_next.slv = HBPA_S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{arb: HBPA_IDLE, slv: HBPA_S_IDLE, req_n: 1'b1, chain_n: 1'b1,
                  wait_lvl: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Lane split per mode; mode 1 uses the low lane only
  always_ff @(posedge clock_i) begin
    if (wr_lo) begin
      if (cpu_mode_i == `HBPA_MODE1) begin
        regs_reg[st_reg.addr[6:0]] <= bus.data_host[7:0];
      end else begin
        regs_reg[(cpu_mode_i == `HBPA_MODE0) ? ev_a[6:0] : od_a[6:0]] <= bus.data_host[7:0];
      end
    end
    if (wr_hi) begin
      regs_reg[(cpu_mode_i == `HBPA_MODE0) ? od_a[6:0] : ev_a[6:0]] <= bus.data_host[15:8];
    end
  end

  assign bus.bus_request_n = st_reg.req_n;
  assign bus.hold_req = !st_reg.req_n && (cpu_mode_i == `HBPA_MODE0);
  assign bus.busy_o_dev = 1'b0;
  assign bus.busy_oe_dev = st_reg.busy_oe;
  assign bus.grant_chain_out_n = st_reg.chain_n;
  assign bus.data_dev = st_reg.dout;
  assign bus.data_oe_dev = st_reg.doe;
  assign bus.wait_lvl = st_reg.wait_lvl;
  assign dma_go_o = st_reg.go;
endmodule

// ==== hw/hbpa_map.svh ====
// Constants of the host bus port with arbiter
// Notes on behaviour
// - DMA request drives bus request low
// - Take bus on grant low, busy high
// - Claim busy, then start DMA cycle
// - Serviced: drop request, release busy together
// - Busy is open-drain, needs pull-up
// - Pre-granted: claim busy when seen high
// - Pre-granted: then request, block grant chain
// - Grant withdrawn: chain out goes high
// - Withdrawn grant: finish cycle, release, retry
// - Mode 0 uses active-high hold pair
// - Width and lane order follow mode
// - Shortest slave cycle lengths per mode
// - Slave access: only wait and data are driven
// - Mode 0 latches byte enable, address
// - Mode 0 read drives data in T3
// - Mode 0 write stores data in T3
// - Mode 0 host idles between cycles
// - Mode 1 latches address, cs returns high
// - Mode 1 read drives data T3/T4
// - Unwanted grant passes down the chain
`ifndef HBPA_MAP_SVH
`define HBPA_MAP_SVH
`define HBPA_MODE0 2'h0
`define HBPA_MODE1 2'h1
`define HBPA_MODE2 2'h2
`define HBPA_MODE3 2'h3
`define HBPA_DMA_STATES 2'h3
`define HBPA_REGS 128
`define HBPA_ADDR_W 8
`define HBPA_DATA_W 16
`define HBPA_DRIVE_T 3'h2
`define HBPA_M0_STORE_T 3'h2
`define HBPA_M1_DRIVE_T 3'h2
`define HBPA_M1_STORE_T 3'h3
`endif

// ==== hw/hbpa_pkg.sv ====
// Types of the host bus port with arbiter
package hbpa_pkg;
  typedef enum logic [4:0] {
    HBPA_IDLE = 5'h01,
    HBPA_REQ = 5'h02,
    HBPA_CLAIM = 5'h04,
    HBPA_DMA = 5'h08,
    HBPA_REL = 5'h10
  } hbpa_arb_t;
  typedef enum logic [3:0] {
    HBPA_S_IDLE = 4'h1,
    HBPA_S_WAIT = 4'h2,
    HBPA_S_ACT = 4'h4,
    HBPA_S_END = 4'h8
  } hbpa_slv_t;
  typedef enum logic [3:0] {
    HBPA_H_IDLE = 4'h1,
    HBPA_H_STRB = 4'h2,
    HBPA_H_HOLD = 4'h4,
    HBPA_H_GAP = 4'h8
  } hbpa_host_t;
endpackage

// ==== hw/hbpa_if.sv ====
// Pins between the port and the host side
`timescale 1ns/1ps
interface hbpa_if;
  logic bus_request_n;
  logic hold_req;
  logic bus_grant_n;
  logic hold_grant;
  logic busy_o_dev;
  logic busy_oe_dev;
  logic busy_oe_host;
  logic busy;
  logic grant_chain_out_n;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic high_byte_enable_n;
  logic [7:0] addr;
  logic [15:0] data_host;
  logic data_oe_host;
  logic [15:0] data_dev;
  logic data_oe_dev;
  logic wait_lvl;
  // Open-drain busy with pull-up
  assign busy = !(busy_oe_dev || busy_oe_host);
  modport dev (
    output bus_request_n, hold_req, busy_o_dev, busy_oe_dev, grant_chain_out_n,
    output data_dev, data_oe_dev, wait_lvl,
    input bus_grant_n, hold_grant, busy, cs_n, rd_n, wr_n, high_byte_enable_n,
    input addr, data_host, data_oe_host
  );
  modport host (
    input bus_request_n, hold_req, busy, grant_chain_out_n, data_dev, data_oe_dev,
    input wait_lvl,
    output bus_grant_n, hold_grant, busy_oe_host, cs_n, rd_n, wr_n,
    output high_byte_enable_n, addr, data_host, data_oe_host
  );
endinterface

// ==== hw/hbpa_host.sv ====
// Host end: grants the bus and runs slave cycles
`timescale 1ns/1ps
`include "hbpa_map.svh"
module hbpa_host import hbpa_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cpu_mode_i,
  input wire logic grant_en_i,
  input wire logic other_busy_i,
  input wire logic start_i,
  input wire logic is_read_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic done_o,
  output logic req_seen_o,
  hbpa_if.host bus
);
  typedef struct packed {
    hbpa_host_t st;
    logic grant;
    logic other;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [15:0] wd;
    logic [15:0] rd;
    logic done;
    logic seen;
    logic [2:0] t;
  } hbpa_host_st_t;
  hbpa_host_st_t st_reg, st_next;
  logic req;

  // mode 0 request is active high
  assign req = (cpu_mode_i == `HBPA_MODE0) ? bus.hold_req : !bus.bus_request_n;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.seen = req;
    // Another master in use also draws a grant
    st_next.grant = (req || other_busy_i) && grant_en_i;
    st_next.other = other_busy_i;
    case (st_reg.st)
      HBPA_H_IDLE: begin
        if (start_i) begin
          st_next.cs_n = 1'b0;
          st_next.addr = addr_i;
          st_next.wd = wdata_i;
          st_next.t = 3'h0;
          st_next.st = HBPA_H_STRB;
        end
      end
      HBPA_H_STRB: begin
        st_next.rd_n = !is_read_i;
        st_next.wr_n = is_read_i;
        st_next.st = HBPA_H_HOLD;
      end
      HBPA_H_HOLD: begin
        st_next.t = st_reg.t + 3'h1;
        if (st_reg.t == `HBPA_M1_STORE_T + 3'h1) begin
          st_next.rd = bus.data_dev;
          st_next.rd_n = 1'b1;
          st_next.wr_n = 1'b1;
          st_next.done = 1'b1;
          st_next.st = HBPA_H_GAP;
        end
      end
      HBPA_H_GAP: begin
        st_next.cs_n = 1'b1;
        st_next.st = HBPA_H_IDLE;
      end
      default: st_next.st = HBPA_H_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{st: HBPA_H_IDLE, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // mode taken as a static strap
  assign bus.bus_grant_n = !st_reg.grant;
  assign bus.hold_grant = st_reg.grant;
  assign bus.busy_oe_host = st_reg.other;
  assign bus.cs_n = st_reg.cs_n;
  assign bus.rd_n = st_reg.rd_n;
  assign bus.wr_n = st_reg.wr_n;
  assign bus.high_byte_enable_n = 1'b0;
  assign bus.addr = st_reg.addr;
  assign bus.data_host = st_reg.wd;
  assign bus.data_oe_host = !st_reg.wr_n;
  assign rdata_o = st_reg.rd;
  assign done_o = st_reg.done;
  assign req_seen_o = st_reg.seen;
endmodule

// ==== tb/hbpa_sva.sv ====
// Assertion checker on the pins between the two ends
`timescale 1ns/1ps
module hbpa_sva (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] cpu_mode_i,
  input wire logic dma_go_o,
  input wire logic bus_request_n,
  input wire logic hold_req,
  input wire logic bus_grant_n,
  input wire logic hold_grant,
  input wire logic busy_oe_dev,
  input wire logic busy,
  input wire logic grant_chain_out_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_oe_dev,
  input wire logic data_oe_host,
  input wire logic wait_lvl
);
  logic m0;
  logic req;
  logic gnt;
  // Mode 0 swaps in the active-high hold pair
  assign m0 = (cpu_mode_i == 2'h0);
  assign req = m0 ? hold_req : !bus_request_n;
  assign gnt = m0 ? hold_grant : !bus_grant_n;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    req && gnt && busy && !busy_oe_dev;
  endsequence
  sequence s_rd_data;
    !data_oe_dev [*3] ##[1:2] data_oe_dev;
  endsequence
  property p_take; s_take |=> busy_oe_dev; endproperty
  a_take: assert property (p_take)
    else $error("bus not claimed after grant");
  property p_claim_go; $rose(busy_oe_dev) && req |=> dma_go_o; endproperty
  a_claim_go: assert property (p_claim_go)
    else $error("no DMA cycle after claim");
  property p_go_space; dma_go_o |=> !dma_go_o [*2]; endproperty
  a_go_space: assert property (p_go_space)
    else $error("DMA cycles closer than three states");
  property p_release; $fell(req) |-> !busy_oe_dev; endproperty
  a_release: assert property (p_release)
    else $error("busy held after request dropped");
  property p_withdraw; busy_oe_dev && !gnt |-> ##[0:4] !busy_oe_dev; endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("bus kept after grant withdrawn");
  property p_chain_block; $fell(gnt) |-> ##[0:1] grant_chain_out_n; endproperty
  a_chain_block: assert property (p_chain_block)
    else $error("chain out not high after grant loss");
  property p_rd_timing; $fell(rd_n) |-> s_rd_data; endproperty
  a_rd_timing: assert property (p_rd_timing)
    else $error("read data not driven in time");
  property p_rd_end; $rose(rd_n) |-> ##[0:2] (!data_oe_dev && wait_lvl); endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("bus not floated after read");
  property p_wr_end; $rose(wr_n) |-> ##[0:2] wait_lvl; endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("wait not raised after write");
  property p_wait_low; $fell(rd_n) || $fell(wr_n) |=> !wait_lvl; endproperty
  a_wait_low: assert property (p_wait_low)
    else $error("wait not lowered during slave cycle");
  property p_no_clash; data_oe_dev |-> !data_oe_host && wr_n; endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("device drives data during write");
endmodule

// ==== tb/tb_top.sv ====
// Bench joining both ends through the pin interface
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  import hbpa_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic rd;
    logic [7:0] a;
    logic [15:0] wd;
    logic [15:0] exp;
  } hbpa_row_t;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] cpu_mode = 2'h1;
  logic dma_req = 1'b0, dma_done = 1'b0, dma_go, grant_en = 1'b1, other_busy = 1'b0;
  logic start = 1'b0, is_read = 1'b0, done, req_seen;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, mask;
  int n_errors = 0, checked = 0, cycles = 0, k;
  // Reads follow writes in the same mode, since a mode change goes through reset
  // Last row reads mode 0 data in mode 3 to see the lanes swap
  hbpa_row_t rows [0:12] = '{
    '{2'h1, 1'b0, 8'h04, 16'h00A5, 16'h0000}, '{2'h1, 1'b0, 8'h06, 16'h003C, 16'h0000},
    '{2'h1, 1'b1, 8'h04, 16'h0000, 16'h00A5}, '{2'h1, 1'b1, 8'h06, 16'h0000, 16'h003C},
    '{2'h0, 1'b0, 8'h10, 16'h1234, 16'h0000}, '{2'h0, 1'b0, 8'h12, 16'hBEEF, 16'h0000},
    '{2'h0, 1'b1, 8'h10, 16'h0000, 16'h1234}, '{2'h0, 1'b1, 8'h12, 16'h0000, 16'hBEEF},
    '{2'h2, 1'b0, 8'h20, 16'h5AA5, 16'h0000}, '{2'h2, 1'b1, 8'h20, 16'h0000, 16'h5AA5},
    '{2'h3, 1'b0, 8'h22, 16'hC3C3, 16'h0000}, '{2'h3, 1'b1, 8'h22, 16'h0000, 16'hC3C3},
    '{2'h3, 1'b1, 8'h10, 16'h0000, 16'h3412}};
  hbpa_if bus_if();
  hbpa_dev i_hbpa_dev (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_mode_i(cpu_mode),
    .dma_req_i(dma_req), .dma_done_i(dma_done), .dma_go_o(dma_go), .bus(bus_if));
  hbpa_host i_hbpa_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_mode_i(cpu_mode),
    .grant_en_i(grant_en), .other_busy_i(other_busy), .start_i(start), .is_read_i(is_read),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .done_o(done), .req_seen_o(req_seen),
    .bus(bus_if));
  hbpa_sva i_hbpa_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_mode_i(cpu_mode),
    .dma_go_o(dma_go), .bus_request_n(bus_if.bus_request_n), .hold_req(bus_if.hold_req),
    .bus_grant_n(bus_if.bus_grant_n), .hold_grant(bus_if.hold_grant),
    .busy_oe_dev(bus_if.busy_oe_dev), .busy(bus_if.busy),
    .grant_chain_out_n(bus_if.grant_chain_out_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n),
    .data_oe_dev(bus_if.data_oe_dev), .data_oe_host(bus_if.data_oe_host),
    .wait_lvl(bus_if.wait_lvl));
  always #12.5 clock_i = ~clock_i;
  function automatic logic req_on(input logic [1:0] m);
    return (m == 2'h0) ? bus_if.hold_req : !bus_if.bus_request_n;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(negedge clock_i);
    rst_n_i = 1'b0;
    cpu_mode = m;
    repeat (4) @(negedge clock_i);
    `CHK({bus_if.wait_lvl, bus_if.data_oe_dev, bus_if.grant_chain_out_n}, 3'h5)
    rst_n_i = 1'b1;
  endtask
  task automatic slave(input hbpa_row_t r);
    @(negedge clock_i);
    is_read = r.rd;
    addr = r.a;
    wdata = r.wd;
    start = 1'b1;
    @(negedge clock_i);
    start = 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clock_i);
    `CHK(done, 1'b1)
    `CHK(bus_if.wait_lvl, 1'b0)
    // Spacing leaves the idle state the host owes between cycles
    repeat (2) @(negedge clock_i);
  endtask
  task automatic wait_go();
    for (k = 0; k < 20 && dma_go !== 1'b1; k++) @(negedge clock_i);
  endtask
  task automatic arb(input logic [1:0] m);
    do_reset(m);
    other_busy = 1'b1;
    repeat (2) @(negedge clock_i);
    `CHK(bus_if.grant_chain_out_n, 1'b0)
    dma_req = 1'b1;
    repeat (8) @(negedge clock_i);
    `CHK(bus_if.busy_oe_dev, 1'b0)
    `CHK(req_on(m), 1'b1)
    other_busy = 1'b0;
    wait_go();
    `CHK(dma_go, 1'b1)
    `CHK(bus_if.busy, 1'b0)
    repeat (3) @(negedge clock_i);
    `CHK(dma_go, 1'b1)
    grant_en = 1'b0;
    for (k = 0; k < 10 && bus_if.busy !== 1'b1; k++) @(negedge clock_i);
    `CHK({bus_if.busy, bus_if.grant_chain_out_n}, 2'h3)
    grant_en = 1'b1;
    wait_go();
    `CHK(dma_go, 1'b1)
    dma_done = 1'b1;
    dma_req = 1'b0;
    for (k = 0; k < 10 && bus_if.busy !== 1'b1; k++) @(negedge clock_i);
    `CHK({bus_if.busy, req_on(m)}, 2'h2)
    @(negedge clock_i);
    dma_done = 1'b0;
    $display("arbiter test in mode %0d done", m);
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    do_reset(2'h1);
    for (int i = 0; i < 13; i++) begin
      if (i > 0 && rows[i].mode != rows[i-1].mode) begin
        do_reset(rows[i].mode);
      end
      slave(rows[i]);
      mask = (rows[i].mode == 2'h1) ? 16'h00FF : 16'hFFFF;
      if (rows[i].rd) begin
        `CHK(rdata & mask, rows[i].exp)
      end
    end
    $display("slave cycle table done");
    arb(2'h1);
    arb(2'h0);
    final_report();
  end
endmodule
